/* File: rtl/dcsd_top.sv */
// Dot clock source select and shift/video clock divider with its two registers.
// Assumes synchronous clock inputs, strobes and register selects on MCLK.
`default_nettype none

module dcsd_top (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic SW_RESET,
    input wire dcsd_pkg::dcsd_clkin_s CLOCK_INPUTS,
    input wire logic [3:0] REGISTER_SELECT_PINS,
    input wire logic RD_N,
    input wire logic WR_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    output logic PIXEL_RATE_CLOCK,
    output logic SHIFT_CLOCK,
    output logic VIDEO_CLOCK_OUT,
    output logic ECL_MODE,
    output logic CLOCKS_STABLE
);
    import dcsd_pkg::*;

    // ----------------------------------------------------------------
    // Decode functions
    // ----------------------------------------------------------------
    function automatic logic pick_src(input logic [3:0] code, input dcsd_clkin_s ck);
        logic res;
        res = 1'b0;
        unique case (code)
            SRC_ZERO: res = ck.clock_input_zero;
            SRC_ONE: res = ck.clock_input_one;
            SRC_TWO: res = ck.clock_input_two;
            SRC_DUAL_P: res = ck.dual_mode_p;
            SRC_DUAL_N: res = ck.dual_mode_n;
            SRC_ECL: res = ck.dual_mode_p & ~ck.dual_mode_n;
            default: res = 1'b0;
        endcase
        return res;
    endfunction : pick_src

    function automatic logic tap(input logic [2:0] code, input logic dot,
                                 input logic [CNT_W-1:0] cnt);
        logic res;
        res = 1'b0;
        unique case (code)
            3'h0: res = dot;
            3'h1: res = cnt[0];
            3'h2: res = cnt[1];
            3'h3: res = cnt[2];
            3'h4: res = cnt[3];
            3'h5: res = cnt[4];
            default: res = 1'b0;
        endcase
        return res;
    endfunction : tap

    // ----------------------------------------------------------------
    // Register access
    // ----------------------------------------------------------------
    logic [7:0] in_sel_r;
    dcsd_outsel_s out_sel_r;
    logic wr_n_prev_r;
    logic wr_take;
    logic wr_in;
    logic wr_out;
    logic [7:0] rd_data_r;

    assign wr_take = CE && !WR_N && wr_n_prev_r;
    assign wr_in = wr_take && (REGISTER_SELECT_PINS == RS_IN_SEL);
    assign wr_out = wr_take && (REGISTER_SELECT_PINS == RS_OUT_SEL);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_n_prev_r <= 1'b1;
        end else if (CE) begin
            wr_n_prev_r <= WR_N;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            in_sel_r <= IN_SEL_RST;
        end else if (CE) begin
            if (SW_RESET) begin
                in_sel_r <= IN_SEL_RST;
            end else if (wr_in) begin
                in_sel_r <= DATA_IN;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            out_sel_r <= dcsd_outsel_s'(OUT_SEL_RST);
        end else if (CE) begin
            if (SW_RESET) begin
                out_sel_r <= dcsd_outsel_s'(OUT_SEL_RST);
            end else if (wr_out) begin
                out_sel_r <= dcsd_outsel_s'(DATA_IN);
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rd_data_r <= 8'h00;
        end else if (CE) begin
            if (REGISTER_SELECT_PINS == RS_IN_SEL) begin
                rd_data_r <= in_sel_r;
            end else if (REGISTER_SELECT_PINS == RS_OUT_SEL) begin
                rd_data_r <= out_sel_r;
            end else begin
                rd_data_r <= 8'h00;
            end
        end
    end

    assign DATA_OUT = rd_data_r;
    assign DATA_OE = !RD_N && ((REGISTER_SELECT_PINS == RS_IN_SEL) ||
                               (REGISTER_SELECT_PINS == RS_OUT_SEL));

    // ----------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------
    logic dot_sel;
    logic dot_q_r;
    logic ecl_r;

    assign dot_sel = pick_src(in_sel_r[SRC_MSB:SRC_LSB], CLOCK_INPUTS);

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            dot_q_r <= 1'b0;
        end else if (CE) begin
            dot_q_r <= dot_sel;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            ecl_r <= 1'b1;
        end else if (CE) begin
            ecl_r <= !((in_sel_r[SRC_MSB:SRC_LSB] == SRC_DUAL_P) ||
                       (in_sel_r[SRC_MSB:SRC_LSB] == SRC_DUAL_N));
        end
    end

    assign PIXEL_RATE_CLOCK = dot_q_r;
    assign ECL_MODE = ecl_r;

    // ----------------------------------------------------------------
    // Shared counter and divided outputs
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic dot_rise;
    logic park_all;
    logic shift_r;
    logic video_r;

    assign dot_rise = dot_sel && !dot_q_r;
    assign park_all = (out_sel_r.video_div[2:1] == PARK_CODE) &&
                      (out_sel_r.shift_div[2:1] == PARK_CODE);

    always_comb begin
        if (park_all) begin
            cnt_nxt = '0;
        end else if (dot_rise) begin
            cnt_nxt = cnt_r + CNT_W'(1);
        end else begin
            cnt_nxt = cnt_r;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r <= '0;
        end else if (CE) begin
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            shift_r <= 1'b0;
        end else if (CE) begin
            if (out_sel_r.shift_div[2:1] == PARK_CODE) begin
                shift_r <= 1'b0;
            end else begin
                shift_r <= tap(out_sel_r.shift_div, dot_sel, cnt_nxt);
            end
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            video_r <= 1'b1;
        end else if (CE) begin
            if (out_sel_r.video_div[2:1] == PARK_CODE) begin
                video_r <= 1'b1;
            end else begin
                video_r <= tap(out_sel_r.video_div, dot_sel, cnt_nxt);
            end
        end
    end

    assign SHIFT_CLOCK = shift_r;
    assign VIDEO_CLOCK_OUT = video_r;

    // ----------------------------------------------------------------
    // Settling status after a selection change
    // ----------------------------------------------------------------
    logic [SETTLE_W-1:0] settle_r;
    logic stable_r;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            settle_r <= '0;
            stable_r <= 1'b1;
        end else if (CE) begin
            if (wr_in || wr_out || SW_RESET) begin
                settle_r <= SETTLE_W'(SETTLE_CYC);
                stable_r <= 1'b0;
            end else if (settle_r != '0) begin
                settle_r <= settle_r - SETTLE_W'(1);
                stable_r <= (settle_r == SETTLE_W'(1));
            end
        end
    end

    assign CLOCKS_STABLE = stable_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    soft_src_a: assert property (CE && SW_RESET |=> in_sel_r[3:0] == SRC_ZERO)
        else $error("software reset did not select input zero");
    dot_pass_a: assert property (CE |=> PIXEL_RATE_CLOCK == $past(dot_sel))
        else $error("dot clock not passed through");
    src_one_a: assert property (in_sel_r[3:0] == SRC_ONE
                                |-> dot_sel == CLOCK_INPUTS.clock_input_one)
        else $error("code one did not pick input one");
    upper_ign_a: assert property ((in_sel_r[7:4] != 4'h0) && (in_sel_r[3:0] == SRC_TWO)
                                  |-> dot_sel == CLOCK_INPUTS.clock_input_two)
        else $error("upper input select bits changed source");
    ecl_mode_a: assert property (CE && in_sel_r[3:0] == SRC_DUAL_N |=> !ECL_MODE)
        else $error("dual input not in TTL use");
    video_park_a: assert property (CE && out_sel_r.video_div[2:1] == PARK_CODE
                                   |=> VIDEO_CLOCK_OUT)
        else $error("video clock not held high");
    shift_park_a: assert property (CE && out_sel_r.shift_div[2:1] == PARK_CODE
                                   |=> !SHIFT_CLOCK)
        else $error("shift clock not held low");
    cnt_clear_a: assert property (CE && park_all |=> cnt_r == '0)
        else $error("counter not cleared while parked");
    cnt_step_a: assert property (CE && !park_all && dot_rise
                                 |=> cnt_r == $past(cnt_r) + 5'h1)
        else $error("counter did not step on dot rise");
    phase_a: assert property (out_sel_r.video_div == 3'h1 && out_sel_r.shift_div == 3'h1
                              && $past(out_sel_r) == out_sel_r
                              |-> VIDEO_CLOCK_OUT == SHIFT_CLOCK)
        else $error("video and shift clocks out of phase");
    video_div1_a: assert property (out_sel_r.video_div == 3'h0
                                   && $past(out_sel_r.video_div) == 3'h0
                                   |-> VIDEO_CLOCK_OUT == PIXEL_RATE_CLOCK)
        else $error("video divide by one differs from dot clock");
    shift_div2_a: assert property (CE && out_sel_r.shift_div == 3'h1
                                   |=> SHIFT_CLOCK == cnt_r[0])
        else $error("shift divide by two not counter bit zero");
    soft_park_a: assert property (CE && SW_RESET |=> out_sel_r == OUT_SEL_RST)
        else $error("software reset did not park clocks");
    settle_a: assert property (CE && wr_out |=> !CLOCKS_STABLE)
        else $error("stable flag not dropped after change");

endmodule : dcsd_top

`default_nettype wire

/* File: shared/dcsd_pkg.sv */
// Constants and carrier types for the dot clock select and divide block.
// Assumes one system clock; the clock inputs are sampled as synchronous levels.
`default_nettype none

package dcsd_pkg;

    // ----------------------------------------------------------------
    // Register select codes
    // ----------------------------------------------------------------
    localparam logic [3:0] RS_IN_SEL = 4'h9;
    localparam logic [3:0] RS_OUT_SEL = 4'ha;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] IN_SEL_RST = 8'h00;
    localparam logic [7:0] OUT_SEL_RST = 8'h36;

    // ----------------------------------------------------------------
    // Source codes and divide fields
    // ----------------------------------------------------------------
    localparam logic [3:0] SRC_ZERO = 4'h0;
    localparam logic [3:0] SRC_ONE = 4'h1;
    localparam logic [3:0] SRC_TWO = 4'h2;
    localparam logic [3:0] SRC_DUAL_P = 4'h3;
    localparam logic [3:0] SRC_DUAL_N = 4'h4;
    localparam logic [3:0] SRC_ECL = 4'h8;
    localparam int SRC_LSB = 0;
    localparam int SRC_MSB = 3;
    localparam logic [1:0] PARK_CODE = 2'h3;
    localparam int CNT_W = 5;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SETTLE_NS = 30;
    localparam int SETTLE_CYC_RAW = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SETTLE_CYC = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
    localparam int SETTLE_W = 4;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] spare;
        logic [2:0] video_div;
        logic [2:0] shift_div;
    } dcsd_outsel_s;

    typedef struct packed {
        logic clock_input_zero;
        logic clock_input_one;
        logic clock_input_two;
        logic dual_mode_p;
        logic dual_mode_n;
    } dcsd_clkin_s;

endpackage : dcsd_pkg

`default_nettype wire

/* File: tb/dcsd_clk_src.sv */
// Model of the five input clock sources, each at its own rate.
// Assumes MCLK and RST_N from the bench; RUN low parks every input low.
`default_nettype none
module dcsd_clk_src import dcsd_pkg::*; (
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic RUN,
    output var dcsd_pkg::dcsd_clkin_s CLK_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] t_r;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            t_r <= 4'h0;
        end else begin
            t_r <= t_r + 4'h1;
        end
    end
    // Stopped sources sit low
    assign CLK_OUT = RUN ? {t_r[0], t_r[1], t_r[2], t_r[3], t_r[0] ^ t_r[2]} : 5'h00;
endmodule : dcsd_clk_src
`default_nettype wire

/* File: tb/tb.sv */
// Bench: register tasks, reference clock model and checks.
// Assumes dcsd_pkg, dcsd_top and dcsd_clk_src are compiled first.
`default_nettype none
module tb import dcsd_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic MCLK = 0, RST_N = 0, CE = 1, SW_RESET = 0, RD_N = 1, WR_N = 1;
    logic run = 0, chk_en = 0, oe, pix, sck, vck, ecl, stb;
    logic pix_m = 0, ecl_m = 1;
    logic [3:0] rs = 4'h0;
    logic [4:0] cnt_m = 5'h00;
    logic [7:0] din = 8'h00, in_m = 8'h00, out_m = 8'h36, dout;
    dcsd_clkin_s ci;
    int n_errors = 0, check_count = 0, cyc = 0;
    logic [15:0] tab [12] = '{16'h0005, 16'h002d, 16'h0112, 16'h021b, 16'h0309,
        16'h0424, 16'h0800, 16'h1801, 16'hf1e8, 16'h050a, 16'he230, 16'h0107};
    initial forever #50 MCLK = ~MCLK;
    dcsd_clk_src i_src (.MCLK(MCLK), .RST_N(RST_N), .RUN(run), .CLK_OUT(ci));
    dcsd_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .SW_RESET(SW_RESET),
        .CLOCK_INPUTS(ci), .REGISTER_SELECT_PINS(rs), .RD_N(RD_N), .WR_N(WR_N),
        .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .PIXEL_RATE_CLOCK(pix),
        .SHIFT_CLOCK(sck), .VIDEO_CLOCK_OUT(vck), .ECL_MODE(ecl), .CLOCKS_STABLE(stb));
    // ----------------------------------------------------------------
    // Reference model
    // ----------------------------------------------------------------
    function automatic logic sel_f(logic [7:0] s, dcsd_clkin_s c);
        case (s[SRC_MSB:SRC_LSB])
            SRC_ZERO: return c.clock_input_zero;
            SRC_ONE: return c.clock_input_one;
            SRC_TWO: return c.clock_input_two;
            SRC_DUAL_P: return c.dual_mode_p;
            SRC_DUAL_N: return c.dual_mode_n;
            SRC_ECL: return c.dual_mode_p & ~c.dual_mode_n;
            default: return 1'b0;
        endcase
    endfunction : sel_f
    function automatic logic dv_f(logic [2:0] k, logic pk);
        if (k == 3'h0) return pix_m;
        if (k > 3'h5) return pk;
        return cnt_m[k - 3'h1];
    endfunction : dv_f
    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_m <= 5'h00;
            pix_m <= 1'b0;
            ecl_m <= 1'b1;
        end else if (CE) begin
            pix_m <= sel_f(in_m, ci);
            if (out_m[5:4] == PARK_CODE && out_m[2:1] == PARK_CODE) begin
                cnt_m <= 5'h00;
            end else if (sel_f(in_m, ci) && !pix_m) begin
                cnt_m <= cnt_m + 5'h01;
            end
            ecl_m <= !(in_m[3:0] == SRC_DUAL_P || in_m[3:0] == SRC_DUAL_N);
        end
    end
    always @(negedge MCLK) begin
        if (chk_en && RST_N) begin
            cmp1(pix, pix_m);
            cmp1(sck, dv_f(out_m[2:0], 1'b0));
            cmp1(vck, dv_f(out_m[5:3], 1'b1));
            cmp1(ecl, ecl_m);
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic cmp1(logic g, logic e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t bit got %b exp %b", $time, g, e);
        end
    endtask : cmp1
    task automatic cmp8(logic [7:0] g, logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
        end
    endtask : cmp8
    task automatic rd(logic [3:0] a, logic [7:0] e);
        rs = a;
        RD_N = 0;
        @(posedge MCLK);
        #1 cmp1(oe, a == RS_IN_SEL || a == RS_OUT_SEL);
        @(posedge MCLK);
        #1 cmp8(dout, e);
        RD_N = 1;
        @(posedge MCLK);
        #1;
    endtask : rd
    task automatic wr(logic [3:0] a, logic [7:0] d);
        chk_en = 0;
        rs = a;
        din = d;
        WR_N = 0;
        @(posedge MCLK);
        #1 WR_N = 1;
        if (a == RS_IN_SEL) in_m = d;
        if (a == RS_OUT_SEL) out_m = d;
        cmp1(stb, !(a == RS_IN_SEL || a == RS_OUT_SEL));
        @(posedge MCLK);
        #1 cmp1(stb, 1'b1);
    endtask : wr
    task automatic wait_chk(int n);
        repeat (2) @(posedge MCLK);
        #1 chk_en = 1;
        repeat (n) @(posedge MCLK);
        #1;
    endtask : wait_chk
    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge MCLK);
        #1 RST_N = 1;
        chk_en = 1;
        rd(RS_IN_SEL, IN_SEL_RST);
        rd(RS_OUT_SEL, OUT_SEL_RST);
        foreach (tab[i]) begin
            run = 0;
            wr(RS_OUT_SEL, OUT_SEL_RST);
            wr(RS_IN_SEL, tab[i][15:8]);
            wr(RS_OUT_SEL, tab[i][7:0]);
            rd(RS_IN_SEL, tab[i][15:8]);
            rd(RS_OUT_SEL, tab[i][7:0]);
            run = 1;
            wait_chk(140);
        end
        CE = 0;
        wait_chk(10);
        CE = 1;
        wr(4'h8, 8'hff);
        rd(4'h8, 8'h00);
        rd(RS_OUT_SEL, 8'h07);
        SW_RESET = 1;
        in_m = IN_SEL_RST;
        out_m = OUT_SEL_RST;
        chk_en = 0;
        @(posedge MCLK);
        #1 SW_RESET = 0;
        rd(RS_IN_SEL, IN_SEL_RST);
        rd(RS_OUT_SEL, OUT_SEL_RST);
        wait_chk(20);
        finish_test();
    end
endmodule : tb
`default_nettype wire
